// ### rtl/rtm_timer.sv
// Reader timer: prescaler, 16-bit down counter, reload and mode registers on APB.
// Assumes clk is the timer reference; tx_end and rx_bit are same-clock pulses.
//
// Notes on behaviour
// - Prescale value is 12 bits: mode low nibble over prescale low byte.
// - Even select clear: tick period is twice prescale value plus one.
// - Even select set: tick period is twice prescale value plus two.
// - Reload value is 16 bits held in two read/write byte registers.
// - Every start event copies the reload value into the counter.
// - Reload writes never disturb a running count; used at next start.
// - Counter shows as two read-only bytes; reset content zero.
// - With auto-restart, exhausted count reloads and counting goes on.
// - Without auto-restart, count stops at zero and sets expired flag.
// - Auto-start starts on transmit end; stops after fifth received bit unless multi-frame receive is set.
`timescale 1ns/1ps
module rtm_timer
	import rtm_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_end,
	input wire logic rx_bit,
	input wire logic multifunction_input_pin,
	input wire logic first_auxiliary_pin,
	output logic timer_expired_flag,
	output logic timer_running
);
	////////////////////////////////////////////////////////////////////////////
	logic [7:0] timer_mode_register;
	logic [7:0] prescale_low_bits;
	logic [7:0] reload_upper_bits;
	logic [7:0] reload_lower_bits;
	logic even_divide_select;
	logic multi_frame_receive;
	logic [15:0] count;
	logic [12:0] presc_cnt;
	logic [2:0] rx_bits;
	logic rx_watch;
	logic [1:0] multi_pin_sync;
	logic [1:0] aux_sync;
	rtm_state_t state;

	// Pin synchronisers, only the second stage is read
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			multi_pin_sync <= 2'h0;
			aux_sync <= 2'h0;
		end else begin
			multi_pin_sync <= {multi_pin_sync[0], multifunction_input_pin};
			aux_sync <= {aux_sync[0], first_auxiliary_pin};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB decode
	wire access = psel && penable && !pready;
	wire wr = access && pwrite;
	wire aligned = (paddr[1:0] == ADDR_ALIGNED);
	wire [5:0] idx = paddr[7:2];
	wire hit_mode = aligned && (idx == IDX_MODE);
	wire hit_presc = aligned && (idx == IDX_PRESC_LO);
	wire hit_rhi = aligned && (idx == IDX_RELOAD_HI);
	wire hit_rlo = aligned && (idx == IDX_RELOAD_LO);
	wire hit_chi = aligned && (idx == IDX_COUNT_HI);
	wire hit_clo = aligned && (idx == IDX_COUNT_LO);
	wire hit_ctrl = aligned && (idx == IDX_CTRL);
	wire hit_stat = aligned && (idx == IDX_STATUS);
	wire mapped = hit_mode || hit_presc || hit_rhi || hit_rlo || hit_chi || hit_clo
		|| hit_ctrl || hit_stat;
	wire [7:0] ctrl_rd = {6'h00, multi_frame_receive, even_divide_select};
	wire [7:0] stat_rd = {6'h00, timer_expired_flag, timer_running};
	wire [7:0] rd_byte = hit_mode ? timer_mode_register :
		hit_presc ? prescale_low_bits :
		hit_rhi ? reload_upper_bits :
		hit_rlo ? reload_lower_bits :
		hit_chi ? count[15:8] :
		hit_clo ? count[7:0] :
		hit_ctrl ? ctrl_rd :
		hit_stat ? stat_rd : BYTE_RESET;

	////////////////////////////////////////////////////////////////////////////
	// Mode fields and prescaler length
	wire auto_start_after_tx = timer_mode_register[MODE_AUTO_BIT];
	wire [1:0] gate_source_select = timer_mode_register[MODE_GATE_HI:MODE_GATE_LO];
	wire auto_restart_enable = timer_mode_register[MODE_RESTART_BIT];
	wire [11:0] prescale_value = {timer_mode_register[MODE_PHI_HI:0], prescale_low_bits};
	wire [12:0] div_len = {prescale_value, 1'b0}
		+ (even_divide_select ? DIV_ADD_EVEN : DIV_ADD_ODD);
	wire [15:0] reload_value = {reload_upper_bits, reload_lower_bits};

	// Gate: open unless the selected pin is low; code 11 treated as ungated
	wire gate_open = (gate_source_select == GATE_MULTI_PIN) ? multi_pin_sync[1] :
		(gate_source_select == GATE_AUX) ? aux_sync[1] : 1'b1;

	// Start and stop events
	wire sw_start = wr && hit_ctrl && pwdata[CTRL_START_BIT];
	wire sw_stop = wr && hit_ctrl && pwdata[CTRL_STOP_BIT];
	wire tx_start = auto_start_after_tx && tx_end;
	wire start_evt = sw_start || tx_start;
	wire rx_stop = rx_watch && rx_bit && !multi_frame_receive
		&& (rx_bits == RX_STOP_BITS - 3'h1);
	wire running = (state == RTM_RUN);
	wire tick = running && !start_evt && (presc_cnt >= div_len - 13'h0001);
	wire step = tick && gate_open;
	wire expire = step && (count == COUNT_RESET);
	wire set_flag = expire && !auto_restart_enable;
	wire clr_flag = wr && hit_stat && pwdata[STAT_FLAG_BIT];

	////////////////////////////////////////////////////////////////////////////
	// APB answer one cycle into the access phase
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= WORD_ZERO;
		end else begin
			pready <= access;
			pslverr <= access && !mapped;
			prdata <= (access && !pwrite) ? {24'h00_0000, rd_byte} : WORD_ZERO;
		end
	end

	// Software registers; reload writes only touch the reload bytes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timer_mode_register <= BYTE_RESET;
			prescale_low_bits <= BYTE_RESET;
			reload_upper_bits <= BYTE_RESET;
			reload_lower_bits <= BYTE_RESET;
			even_divide_select <= 1'b0;
			multi_frame_receive <= 1'b0;
		end else begin
			if (wr && hit_mode) timer_mode_register <= pwdata[7:0];
			if (wr && hit_presc) prescale_low_bits <= pwdata[7:0];
			if (wr && hit_rhi) reload_upper_bits <= pwdata[7:0];
			if (wr && hit_rlo) reload_lower_bits <= pwdata[7:0];
			if (wr && hit_ctrl) begin
				even_divide_select <= pwdata[CTRL_EVEN_BIT];
				multi_frame_receive <= pwdata[CTRL_MULTI_BIT];
			end
		end
	end

	// Timer state machine
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state <= RTM_IDLE;
		end else begin
			case (state)
				RTM_IDLE: begin
					if (start_evt) state <= RTM_RUN;
				end
				RTM_RUN: begin
					if (start_evt) state <= RTM_RUN;
					else if (sw_stop || rx_stop || set_flag) state <= RTM_IDLE;
				end
				default: state <= RTM_IDLE;
			endcase
		end
	end

	// Prescaler and down counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			presc_cnt <= 13'h0000;
			count <= COUNT_RESET;
		end else begin
			presc_cnt <= (start_evt || tick || !running) ? 13'h0000 : presc_cnt + 13'h0001;
			if (start_evt) count <= reload_value;
			else if (expire && auto_restart_enable) count <= reload_value;
			else if (step && !expire) count <= count - 16'h0001;
		end
	end

	// Received-bit watch after an automatic start
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_watch <= 1'b0;
			rx_bits <= 3'h0;
		end else begin
			if (start_evt) rx_watch <= tx_start;
			else if (rx_stop || !running) rx_watch <= 1'b0;
			rx_bits <= start_evt ? 3'h0 : (rx_watch && rx_bit) ? rx_bits + 3'h1 : rx_bits;
		end
	end

	// Expired flag: hardware set wins over software clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			timer_expired_flag <= 1'b0;
			timer_running <= 1'b0;
		end else begin
			timer_expired_flag <= set_flag || (timer_expired_flag && !clr_flag);
			timer_running <= (state == RTM_IDLE) ? start_evt
				: !(!start_evt && (sw_stop || rx_stop || set_flag));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	logic [13:0] gap;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) gap <= 14'h0000;
		else gap <= (start_evt || tick) ? 14'h0000 : gap + 14'h0001;
	end

	property p_presc_join;
		wr && hit_presc |=> prescale_value[7:0] == $past(pwdata[7:0]);
	endproperty
	a_presc_join: assert property (p_presc_join) else $error("prescale low byte lost");

	property p_odd_div;
		tick && !even_divide_select |-> gap + 14'h0001 == {prescale_value, 1'b0} + 14'h0001;
	endproperty
	a_odd_div: assert property (p_odd_div) else $error("odd tick period wrong");

	property p_even_div;
		tick && even_divide_select |-> gap + 14'h0001 == {prescale_value, 1'b0} + 14'h0002;
	endproperty
	a_even_div: assert property (p_even_div) else $error("even tick period wrong");

	property p_reload_hi;
		wr && hit_rhi |=> reload_value[15:8] == $past(pwdata[7:0]);
	endproperty
	a_reload_hi: assert property (p_reload_hi) else $error("reload high not stored");

	property p_start_load;
		start_evt |=> count == $past(reload_value) && running;
	endproperty
	a_start_load: assert property (p_start_load) else $error("start did not load");

	property p_reload_quiet;
		wr && (hit_rhi || hit_rlo) && !start_evt && !step |=> $stable(count);
	endproperty
	a_reload_quiet: assert property (p_reload_quiet) else $error("reload write moved count");

	property p_count_read;
		access && !pwrite && hit_chi |=> pready && prdata[7:0] == $past(count[15:8]);
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read wrong");

	property p_restart;
		expire && auto_restart_enable && !start_evt && !sw_stop && !rx_stop
			|=> count == $past(reload_value) && running;
	endproperty
	a_restart: assert property (p_restart) else $error("no auto restart");

	property p_expire;
		set_flag && !start_evt ##1 !start_evt |-> !running ##0 timer_expired_flag ##1 !running;
	endproperty
	a_expire: assert property (p_expire) else $error("expiry not flagged");

	property p_auto_start;
		tx_end && auto_start_after_tx |=> running ##0 timer_running;
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("auto start missed");

	property p_gate_hold;
		tick && !gate_open |=> $stable(count);
	endproperty
	a_gate_hold: assert property (p_gate_hold) else $error("gated count moved");

	property p_decrement;
		step && !expire && !start_evt |=> count == $past(count) - 16'h0001;
	endproperty
	a_decrement: assert property (p_decrement) else $error("decrement wrong");

	c_expire: cover property (set_flag);
	c_restart: cover property (expire && auto_restart_enable);
	c_rx_stop: cover property (rx_stop);
	c_gated: cover property (tick && !gate_open);
endmodule : rtm_timer

// ### rtl/rtm_pkg.sv
// Package for the reader timer block: register indices, field positions, types.
// Assumes an APB master with 32-bit data; each register sits at byte address 4*index.
package rtm_pkg;
	////////////////////////////////////////////////////////////////////////////
	// Register indices, byte address is four times the index
	localparam logic [5:0] IDX_MODE = 6'h2a;
	localparam logic [5:0] IDX_PRESC_LO = 6'h2b;
	localparam logic [5:0] IDX_RELOAD_HI = 6'h2c;
	localparam logic [5:0] IDX_RELOAD_LO = 6'h2d;
	localparam logic [5:0] IDX_COUNT_HI = 6'h2e;
	localparam logic [5:0] IDX_COUNT_LO = 6'h2f;
	localparam logic [5:0] IDX_CTRL = 6'h3e;
	localparam logic [5:0] IDX_STATUS = 6'h3f;
	localparam logic [1:0] ADDR_ALIGNED = 2'h0;
	////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int MODE_AUTO_BIT = 7;
	localparam int MODE_GATE_HI = 6;
	localparam int MODE_GATE_LO = 5;
	localparam int MODE_RESTART_BIT = 4;
	localparam int MODE_PHI_HI = 3;
	localparam int CTRL_EVEN_BIT = 0;
	localparam int CTRL_MULTI_BIT = 1;
	localparam int CTRL_START_BIT = 2;
	localparam int CTRL_STOP_BIT = 3;
	localparam int STAT_RUN_BIT = 0;
	localparam int STAT_FLAG_BIT = 1;
	////////////////////////////////////////////////////////////////////////////
	// Reset values and constants
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [2:0] RX_STOP_BITS = 3'h5;
	localparam logic [12:0] DIV_ADD_ODD = 13'h0001;
	localparam logic [12:0] DIV_ADD_EVEN = 13'h0002;
	localparam logic [1:0] GATE_NONE = 2'h0;
	localparam logic [1:0] GATE_MULTI_PIN = 2'h1;
	localparam logic [1:0] GATE_AUX = 2'h2;
	////////////////////////////////////////////////////////////////////////////
	// Timer state
	typedef enum logic {
		RTM_IDLE = 1'b0,
		RTM_RUN = 1'b1
	} rtm_state_t;
endpackage : rtm_pkg

// ### test/tb_rtm_timer.sv
// Testbench for the reader timer: APB registers, prescaled countdown, modes, gating.
// Assumes the APB slave answers with one wait state and clk is the timer reference.
`timescale 1ns/1ps
module tb_rtm_timer;
	import rtm_pkg::*;
	logic clk, resetn, psel, penable, pwrite, tx_end, rx_bit, gate_a, gate_b;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, flag, run;
	logic [32:0] expq[$];
	logic [11:0] p;
	int failures, n_tests, d1, d2, per;

	rtm_timer u_dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_end(tx_end), .rx_bit(rx_bit), .multifunction_input_pin(gate_a),
		.first_auxiliary_pin(gate_b), .timer_expired_flag(flag), .timer_running(run));

	////////////////////////////////////////////////////////////////////////////
	// Clock, 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		n_tests++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic end_of_test;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	////////////////////////////////////////////////////////////////////////////
	// APB master; a read notes its expected {pslverr, prdata} in the queue
	task automatic apb(input logic w, input logic [5:0] idx, input logic [7:0] d,
			input logic [32:0] e);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, ADDR_ALIGNED};
		pwdata <= {24'h00_0000, d};
		if (!w) expq.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) begin
			failures++;
			end_of_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 33'h0_0000_0000);
	endtask : wr

	task automatic rd(input logic [5:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 8'h00, {25'h000_0000, e});
	endtask : rd

	// Start a countdown and count cycles until the timer stops by itself
	task automatic timed(input logic [15:0] rl, input logic [7:0] c, output int n);
		wr(IDX_RELOAD_HI, rl[15:8]);
		wr(IDX_RELOAD_LO, rl[7:0]);
		wr(IDX_STATUS, 8'h02);
		wr(IDX_CTRL, c);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (run === 1'b1 && n < 20000);
		check("expired flag", 33'(flag), 33'h0_0000_0001);
		check("running after expiry", 33'(run), 33'h0_0000_0000);
	endtask : timed

	////////////////////////////////////////////////////////////////////////////
	// Monitor: each read answer is compared with the oldest note
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) begin
			check("read data", {pslverr, prdata}, expq.pop_front());
		end
	end

	// Watchdog
	initial begin
		#(100 * 60000);
		failures++;
		end_of_test();
	end

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{psel, penable, pwrite, tx_end, rx_bit, gate_a, gate_b, resetn} = 8'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		failures = 0;
		n_tests = 0;
		void'($urandom(32'hbc74));
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		rd(IDX_PRESC_LO, 8'h00);
		rd(IDX_RELOAD_HI, 8'h00);
		rd(IDX_RELOAD_LO, 8'h00);
		wr(IDX_RELOAD_HI, 8'ha5);
		wr(IDX_RELOAD_LO, 8'h3c);
		wr(IDX_COUNT_LO, 8'h77);
		rd(IDX_RELOAD_HI, 8'ha5);
		rd(IDX_RELOAD_LO, 8'h3c);
		rd(IDX_COUNT_LO, 8'h00);
		apb(1'b0, 6'h30, 8'h00, {1'b1, 32'h0000_0000});
		// Tick period from two reload lengths, odd then even divide
		for (int ev = 0; ev < 2; ev++) begin
			p = 12'(($urandom % 2) * 256 + ($urandom % 8));
			wr(IDX_MODE, {4'h0, p[11:8]});
			wr(IDX_PRESC_LO, p[7:0]);
			rd(IDX_MODE, {4'h0, p[11:8]});
			timed(16'h0002, {7'h02, ev[0]}, d1);
			timed(16'h0005, {7'h02, ev[0]}, d2);
			per = 2 * int'(p) + 1 + ev;
			check("tick period", 33'(d2 - d1), 33'(3 * per));
		end
		// Reload writes during a run only act at the next start
		wr(IDX_MODE, 8'h00);
		wr(IDX_PRESC_LO, 8'h14);
		wr(IDX_RELOAD_HI, 8'h00);
		wr(IDX_RELOAD_LO, 8'h10);
		wr(IDX_CTRL, 8'h04);
		wr(IDX_RELOAD_HI, 8'hff);
		rd(IDX_COUNT_HI, 8'h00);
		wr(IDX_CTRL, 8'h04);
		rd(IDX_COUNT_HI, 8'hff);
		wr(IDX_CTRL, 8'h08);
		// Auto-restart keeps running with no flag
		wr(IDX_PRESC_LO, 8'h00);
		wr(IDX_RELOAD_HI, 8'h00);
		wr(IDX_RELOAD_LO, 8'h03);
		wr(IDX_STATUS, 8'h02);
		wr(IDX_MODE, 8'h10);
		wr(IDX_CTRL, 8'h04);
		repeat (40) @(negedge clk);
		check("restart running", 33'(run), 33'h0_0000_0001);
		check("restart flag", 33'(flag), 33'h0_0000_0000);
		wr(IDX_CTRL, 8'h08);
		// Auto-start on transmit end, stop after the fifth received bit
		wr(IDX_MODE, 8'h80);
		wr(IDX_RELOAD_HI, 8'hff);
		@(posedge clk);
		tx_end <= 1'b1;
		@(posedge clk);
		tx_end <= 1'b0;
		repeat (3) @(negedge clk);
		check("auto start", 33'(run), 33'h0_0000_0001);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			rx_bit <= 1'b1;
			@(posedge clk);
			rx_bit <= 1'b0;
			repeat (3) @(negedge clk);
			check("rx bit stop", 33'(run), 33'(i < 4));
		end
		// Multi-frame receive keeps an auto-started timer running past five bits
		wr(IDX_CTRL, 8'h02);
		rd(IDX_CTRL, 8'h02);
		@(posedge clk);
		tx_end <= 1'b1;
		@(posedge clk);
		tx_end <= 1'b0;
		repeat (5) begin
			@(posedge clk);
			rx_bit <= 1'b1;
			@(posedge clk);
			rx_bit <= 1'b0;
		end
		repeat (3) @(negedge clk);
		check("multi frame run", 33'(run), 33'h0_0000_0001);
		rd(IDX_STATUS, 8'h01);
		wr(IDX_CTRL, 8'h08);
		// Gating by each pin, the other pin held open; code 11 runs ungated
		for (int g = 1; g < 4; g++) begin
			wr(IDX_MODE, {1'b0, 2'(g), 5'h00});
			gate_a <= (g == 2);
			gate_b <= (g == 1);
			wr(IDX_RELOAD_HI, 8'h00);
			wr(IDX_RELOAD_LO, 8'h04);
			wr(IDX_STATUS, 8'h02);
			wr(IDX_CTRL, 8'h04);
			repeat (30) @(negedge clk);
			check("gate closed", 33'(run), 33'(g < 3));
			gate_a <= 1'b1;
			gate_b <= 1'b1;
			repeat (30) @(negedge clk);
			check("gate open", {31'h0000_0000, run, flag}, 33'h0_0000_0001);
		end
		rd(IDX_STATUS, 8'h02);
		wr(IDX_STATUS, 8'h02);
		rd(IDX_STATUS, 8'h00);
		repeat (4) @(posedge clk);
		end_of_test();
	end
endmodule : tb_rtm_timer
